/* hdl/sfwm_pkg.sv */
// constants shared by the serial fifo watermark controller
package sfwm_pkg;
  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // fifo geometry
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W      = 5;
  localparam int WM_W       = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FIFO_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_REQ_EN    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TX_DATA   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RX_DATA   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h14;

  // fifo_threshold_and_level field positions
  localparam int TX_WM_LSB = 13;
  localparam int TX_UA_LSB = 8;
  localparam int RX_WM_LSB = 5;
  localparam int RX_UA_LSB = 0;

  // request_enable_register bit positions and writable mask
  localparam int TX_DMA_BIT    = 15;
  localparam int TX_REQ_EN_BIT = 12;
  localparam int RX_DMA_BIT    = 11;
  localparam int RX_REQ_EN_BIT = 8;
  localparam logic [DATA_W-1:0] REQ_EN_MASK = 16'h9900;

  // interrupt status bit positions
  localparam int ST_TX_REQ = 0;
  localparam int ST_RX_REQ = 1;
  localparam int ST_TX_OVF = 2;
  localparam int ST_TX_UDF = 3;
  localparam int ST_RX_OVF = 4;
  localparam int ST_RX_UDF = 5;
  localparam int ST_W      = 6;

  // watermark codes
  localparam logic [WM_W-1:0] WM_000 = 3'h0;
  localparam logic [WM_W-1:0] WM_100 = 3'h4;
  localparam logic [WM_W-1:0] WM_101 = 3'h5;
  localparam logic [WM_W-1:0] WM_110 = 3'h6;
  localparam logic [WM_W-1:0] WM_111 = 3'h7;
  localparam logic [WM_W-1:0] WM_RESET = 3'h0;

  // thresholds in stages
  localparam logic [LVL_W-1:0] THR_1  = 5'h01;
  localparam logic [LVL_W-1:0] THR_4  = 5'h04;
  localparam logic [LVL_W-1:0] THR_8  = 5'h08;
  localparam logic [LVL_W-1:0] THR_12 = 5'h0c;
  localparam logic [LVL_W-1:0] THR_16 = 5'h10;
endpackage

/* hdl/sfwm_fifo.sv */
// sixteen-stage word fifo with occupancy count and look-ahead count
`timescale 1ns/1ns
`default_nettype none
module sfwm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  // filling side
  input  wire logic                     push,
  input  wire logic [WIDTH-1:0]         push_data,
  // draining side
  input  wire logic                     pop,
  output logic      [WIDTH-1:0]         head,
  // state
  output logic      [$clog2(DEPTH):0]   count,
  output logic      [$clog2(DEPTH):0]   count_nxt,
  output logic                          full,
  output logic                          empty
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
  localparam logic [PW:0] ONE_C   = (PW+1)'(1);

  // refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
    $error("sfwm_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  wire              do_push;
  wire              do_pop;

  // full depth always in use, never cut by the watermark
  assign full    = (count_r == DEPTH_C);
  assign empty   = (count_r == '0);
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  assign head    = mem[rd_ptr_r];
  assign count   = count_r;

  // occupancy after this edge
  always_comb begin
    count_nxt = count_r;
    if (do_push && !do_pop) begin
      count_nxt = count_r + ONE_C;
    end else if (do_pop && !do_push) begin
      count_nxt = count_r - ONE_C;
    end
  end

  // storage write
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= push_data;
    end
  end

  // pointers and count
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + PW'(1);
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + PW'(1);
      end
      count_r <= count_nxt;
    end
  end
endmodule
`default_nettype wire

/* hdl/sfwm_thresh.sv */
// watermark code decoder and level comparator
`timescale 1ns/1ns
`default_nettype none
module sfwm_thresh #(
  parameter bit RX = 1'b0
) (
  // watermark code and level in stages
  input  wire logic [sfwm_pkg::WM_W-1:0]  code,
  input  wire logic [sfwm_pkg::LVL_W-1:0] level,
  // threshold met
  output logic                            hit
);
  logic [sfwm_pkg::LVL_W-1:0] thr;

  // prohibited codes fall back to the 000 threshold
  always_comb begin
    thr = RX ? sfwm_pkg::THR_1 : sfwm_pkg::THR_16;
    case (code)
      sfwm_pkg::WM_100: thr = RX ? sfwm_pkg::THR_4  : sfwm_pkg::THR_12;
      sfwm_pkg::WM_101: thr = sfwm_pkg::THR_8;
      sfwm_pkg::WM_110: thr = RX ? sfwm_pkg::THR_12 : sfwm_pkg::THR_4;
      sfwm_pkg::WM_111: thr = RX ? sfwm_pkg::THR_16 : sfwm_pkg::THR_1;
      default:          thr = RX ? sfwm_pkg::THR_1  : sfwm_pkg::THR_16;
    endcase
  end

  assign hit = (level >= thr);
endmodule
`default_nettype wire

/* hdl/sfwm_top.sv */
// serial fifo watermark controller: fifos, levels, requests, registers
`timescale 1ns/1ns
`default_nettype none
module sfwm_top #(
  parameter int WORD_W     = 16,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  // register port
  input  wire logic [sfwm_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [sfwm_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [sfwm_pkg::DATA_W-1:0]  reg_rdata,
  // transmit shift logic
  input  wire logic                         tx_shift_pop,
  output logic      [WORD_W-1:0]            tx_shift_word,
  output logic                              tx_shift_valid,
  output logic                              tx_fifo_empty,
  // receive shift logic
  input  wire logic                         rx_shift_push,
  input  wire logic [WORD_W-1:0]            rx_shift_word,
  output logic                              rx_fifo_full,
  // dma requests and cpu interrupt
  output logic                              tx_dma_req,
  output logic                              rx_dma_req,
  output logic                              irq
);
  localparam int LW = sfwm_pkg::LVL_W;
  localparam int DW = sfwm_pkg::DATA_W;
  localparam int WW = sfwm_pkg::WM_W;
  localparam logic [LW-1:0] DEPTH_C = LW'(sfwm_pkg::FIFO_DEPTH);

  // refuse settings the thresholds and register layout cannot serve
  if (FIFO_DEPTH != sfwm_pkg::FIFO_DEPTH) begin : g_chk_depth
    $error("sfwm_top fifo depth must match the 16-stage thresholds");
  end
  if (WORD_W < 1 || WORD_W > sfwm_pkg::DATA_W) begin : g_chk_word
    $error("sfwm_top word width must fit the register data");
  end

  // registers
  logic [WW-1:0]        tx_wm_r;
  logic [WW-1:0]        rx_wm_r;
  logic [DW-1:0]        req_en_r;
  logic [sfwm_pkg::ST_W-1:0] stat_r;
  logic [sfwm_pkg::ST_W-1:0] mask_r;
  logic [DW-1:0]        rdata_r;
  logic [WORD_W-1:0]    tx_word_r;
  logic                 tx_valid_r;
  logic                 tx_empty_r;
  logic                 rx_full_r;
  logic                 tx_dma_r;
  logic                 rx_dma_r;
  logic                 irq_r;

  // address decode
  wire sel_ctrl = (reg_addr == sfwm_pkg::OFS_FIFO_CTRL);
  wire sel_en   = (reg_addr == sfwm_pkg::OFS_REQ_EN);
  wire sel_txd  = (reg_addr == sfwm_pkg::OFS_TX_DATA);
  wire sel_rxd  = (reg_addr == sfwm_pkg::OFS_RX_DATA);
  wire sel_stat = (reg_addr == sfwm_pkg::OFS_IRQ_STAT);
  wire sel_mask = (reg_addr == sfwm_pkg::OFS_IRQ_MASK);

  // strobes per register
  wire wr_ctrl  = reg_wr & sel_ctrl;
  wire wr_en    = reg_wr & sel_en;
  wire wr_txd   = reg_wr & sel_txd;
  wire wr_mask  = reg_wr & sel_mask;
  wire rd_rxd   = reg_rd & sel_rxd;
  wire rd_stat  = reg_rd & sel_stat;

  // fifo status wires
  wire [WORD_W-1:0] tx_head;
  wire [WORD_W-1:0] rx_head;
  wire [LW-1:0]     tx_count;
  wire [LW-1:0]     tx_count_nxt;
  wire [LW-1:0]     rx_count;
  wire [LW-1:0]     rx_count_nxt;
  wire              tx_full;
  wire              tx_empty;
  wire              rx_full;
  wire              rx_empty;

  // transfer events and errors
  wire tx_ovf_ev = wr_txd & tx_full;
  wire tx_udf_ev = tx_shift_pop & tx_empty;
  wire rx_ovf_ev = rx_shift_push & rx_full;
  wire rx_udf_ev = rd_rxd & rx_empty;

  // transmit fifo, filled by software or dma, drained by the shifter
  sfwm_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .push      (wr_txd),
    .push_data (reg_wdata[WORD_W-1:0]),
    .pop       (tx_shift_pop),
    .head      (tx_head),
    .count     (tx_count),
    .count_nxt (tx_count_nxt),
    .full      (tx_full),
    .empty     (tx_empty)
  );

  // receive fifo, filled by the shifter, drained by software or dma
  sfwm_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .reset     (reset),
    .push      (rx_shift_push),
    .push_data (rx_shift_word),
    .pop       (rd_rxd),
    .head      (rx_head),
    .count     (rx_count),
    .count_nxt (rx_count_nxt),
    .full      (rx_full),
    .empty     (rx_empty)
  );

  // usable words: free space for transmit, valid words for receive
  wire [LW-1:0] tx_usable     = DEPTH_C - tx_count;
  wire [LW-1:0] tx_usable_nxt = DEPTH_C - tx_count_nxt;
  wire [LW-1:0] rx_usable     = rx_count;

  // next values of the control fields, so requests track the edge exactly
  wire [WW-1:0] tx_wm_nxt  = wr_ctrl ? reg_wdata[sfwm_pkg::TX_WM_LSB +: WW] : tx_wm_r;
  wire [WW-1:0] rx_wm_nxt  = wr_ctrl ? reg_wdata[sfwm_pkg::RX_WM_LSB +: WW] : rx_wm_r;
  wire [DW-1:0] req_en_nxt = wr_en ? (reg_wdata & sfwm_pkg::REQ_EN_MASK) : req_en_r;
  wire [sfwm_pkg::ST_W-1:0] mask_nxt = wr_mask ? reg_wdata[sfwm_pkg::ST_W-1:0] : mask_r;

  // watermark comparators on the post-edge levels
  wire tx_hit;
  wire rx_hit;

  sfwm_thresh #(
    .RX (1'b0)
  ) u_tx_thresh (
    .code  (tx_wm_nxt),
    .level (tx_usable_nxt),
    .hit   (tx_hit)
  );

  sfwm_thresh #(
    .RX (1'b1)
  ) u_rx_thresh (
    .code  (rx_wm_nxt),
    .level (rx_count_nxt),
    .hit   (rx_hit)
  );

  // request enables and routing selects
  wire tx_req_en  = req_en_nxt[sfwm_pkg::TX_REQ_EN_BIT];
  wire rx_req_en  = req_en_nxt[sfwm_pkg::RX_REQ_EN_BIT];
  wire tx_dma_sel = req_en_nxt[sfwm_pkg::TX_DMA_BIT];
  wire rx_dma_sel = req_en_nxt[sfwm_pkg::RX_DMA_BIT];

  // data requests gated by their enables
  wire tx_req = tx_hit & tx_req_en;
  wire rx_req = rx_hit & rx_req_en;

  // route each request to dma or to the cpu interrupt
  wire tx_dma_nxt = tx_req & tx_dma_sel;
  wire rx_dma_nxt = rx_req & rx_dma_sel;
  wire tx_cpu_ev  = tx_req & ~tx_dma_sel;
  wire rx_cpu_ev  = rx_req & ~rx_dma_sel;

  // sticky status: read clears, a set in the same cycle wins
  logic [sfwm_pkg::ST_W-1:0] stat_set;
  always_comb begin
    stat_set = '0;
    stat_set[sfwm_pkg::ST_TX_REQ] = tx_cpu_ev;
    stat_set[sfwm_pkg::ST_RX_REQ] = rx_cpu_ev;
    stat_set[sfwm_pkg::ST_TX_OVF] = tx_ovf_ev;
    stat_set[sfwm_pkg::ST_TX_UDF] = tx_udf_ev;
    stat_set[sfwm_pkg::ST_RX_OVF] = rx_ovf_ev;
    stat_set[sfwm_pkg::ST_RX_UDF] = rx_udf_ev;
  end
  wire [sfwm_pkg::ST_W-1:0] stat_keep = rd_stat ? '0 : stat_r;
  wire [sfwm_pkg::ST_W-1:0] stat_nxt  = stat_keep | stat_set;
  wire                      irq_nxt   = |(stat_nxt & mask_nxt);

  // packed view of fifo_threshold_and_level
  logic [DW-1:0] ctrl_view;
  always_comb begin
    ctrl_view = '0;
    ctrl_view[sfwm_pkg::TX_WM_LSB +: WW] = tx_wm_r;
    ctrl_view[sfwm_pkg::TX_UA_LSB +: LW] = tx_usable;
    ctrl_view[sfwm_pkg::RX_WM_LSB +: WW] = rx_wm_r;
    ctrl_view[sfwm_pkg::RX_UA_LSB +: LW] = rx_usable;
  end

  // read mux; unmapped offsets and the tx data port read zero
  logic [DW-1:0] rsel;
  always_comb begin
    rsel = '0;
    if (sel_ctrl) begin
      rsel = ctrl_view;
    end else if (sel_en) begin
      rsel = req_en_r;
    end else if (sel_rxd && !rx_empty) begin
      rsel[WORD_W-1:0] = rx_head;
    end else if (sel_stat) begin
      rsel[sfwm_pkg::ST_W-1:0] = stat_r;
    end else if (sel_mask) begin
      rsel[sfwm_pkg::ST_W-1:0] = mask_r;
    end
  end
  wire [DW-1:0] rdata_nxt = reg_rd ? rsel : '0;

  // transmit watermark field
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_wm_r <= sfwm_pkg::WM_RESET;
    end else begin
      tx_wm_r <= tx_wm_nxt;
    end
  end

  // receive watermark field
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_wm_r <= sfwm_pkg::WM_RESET;
    end else begin
      rx_wm_r <= rx_wm_nxt;
    end
  end

  // request enables and dma selects
  always_ff @(posedge core_clk) begin
    if (reset) begin
      req_en_r <= '0;
    end else begin
      req_en_r <= req_en_nxt;
    end
  end

  // sticky interrupt status
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // interrupt mask
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mask_r <= '0;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // level interrupt, tracks status and mask with the same edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // register read data, valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // transmit word valid, one cycle after a pop that found a word
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_valid_r <= 1'b0;
    end else begin
      tx_valid_r <= tx_shift_pop & ~tx_empty;
    end
  end

  // transmit word to the shifter, held until the next good pop
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_word_r <= '0;
    end else if (tx_shift_pop && !tx_empty) begin
      tx_word_r <= tx_head;
    end
  end

  // fifo flags on post-edge occupancy
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_empty_r <= 1'b1;
      rx_full_r  <= 1'b0;
    end else begin
      tx_empty_r <= (tx_count_nxt == '0);
      rx_full_r  <= (rx_count_nxt == DEPTH_C);
    end
  end

  // dma requests on post-edge levels and settings
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_dma_r <= 1'b0;
      rx_dma_r <= 1'b0;
    end else begin
      tx_dma_r <= tx_dma_nxt;
      rx_dma_r <= rx_dma_nxt;
    end
  end

  // outputs straight from flops
  assign reg_rdata      = rdata_r;
  assign tx_shift_word  = tx_word_r;
  assign tx_shift_valid = tx_valid_r;
  assign tx_fifo_empty  = tx_empty_r;
  assign rx_fifo_full   = rx_full_r;
  assign tx_dma_req     = tx_dma_r;
  assign rx_dma_req     = rx_dma_r;
  assign irq            = irq_r;
endmodule
`default_nettype wire

/* tb/sfwm_top_sva.sv */
// port-level checks for the fifo watermark controller
`timescale 1ns/1ns
`default_nettype none
module sfwm_chk (
  // clock and reset
  input wire logic                        core_clk,
  input wire logic                        reset,
  // register port
  input wire logic [sfwm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sfwm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [sfwm_pkg::DATA_W-1:0] reg_rdata,
  // shift side and requests
  input wire logic                        tx_shift_pop,
  input wire logic                        tx_shift_valid,
  input wire logic                        tx_fifo_empty,
  input wire logic                        rx_fifo_full,
  input wire logic                        tx_dma_req,
  input wire logic                        rx_dma_req,
  input wire logic                        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [2:0]  tx_wm_r;
  logic [2:0]  rx_wm_r;
  logic [15:0] en_r;
  logic [5:0]  mask_r;
  // shadow copies of the writable settings
  wire wr_ctl  = reg_wr && (reg_addr == sfwm_pkg::OFS_FIFO_CTRL);
  wire wr_en   = reg_wr && (reg_addr == sfwm_pkg::OFS_REQ_EN);
  wire wr_mask = reg_wr && (reg_addr == sfwm_pkg::OFS_IRQ_MASK);
  wire tx000   = (tx_wm_r == 3'h0) && en_r[15] && en_r[12];
  wire rx111   = (rx_wm_r == 3'h7) && en_r[11] && en_r[8];
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_wm_r <= 3'h0;
      rx_wm_r <= 3'h0;
      en_r    <= 16'h0000;
      mask_r  <= 6'h00;
    end else begin
      if (wr_ctl) tx_wm_r <= reg_wdata[15:13];
      if (wr_ctl) rx_wm_r <= reg_wdata[7:5];
      if (wr_en) en_r <= reg_wdata & sfwm_pkg::REQ_EN_MASK;
      if (wr_mask) mask_r <= reg_wdata[5:0];
    end
  end
  sequence s_pop_ok;
    tx_shift_pop && !tx_fifo_empty;
  endsequence
  sequence s_en_read;
    reg_rd && (reg_addr == sfwm_pkg::OFS_REQ_EN);
  endsequence
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  property p_en_read;
    s_en_read |=> reg_rdata == $past(en_r);
  endproperty
  property p_pop_valid;
    s_pop_ok |=> tx_shift_valid;
  endproperty
  property p_no_valid;
    !tx_shift_pop |=> !tx_shift_valid;
  endproperty
  property p_tx000;
    tx000 |-> tx_dma_req == tx_fifo_empty;
  endproperty
  property p_rx111;
    rx111 |-> rx_dma_req == rx_fifo_full;
  endproperty
  property p_tx_gate;
    !en_r[12] |-> !tx_dma_req;
  endproperty
  property p_tx_route;
    !en_r[15] |-> !tx_dma_req;
  endproperty
  property p_rx_route;
    !en_r[11] || !en_r[8] |-> !rx_dma_req;
  endproperty
  property p_irq_mask;
    mask_r == 6'h00 |-> !irq;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_en_read: assert property (p_en_read) else $error("enable readback wrong");
  a_pop_valid: assert property (p_pop_valid) else $error("pop gave no word");
  a_no_valid: assert property (p_no_valid) else $error("word without pop");
  a_tx000: assert property (p_tx000) else $error("tx code 000 request wrong");
  a_rx111: assert property (p_rx111) else $error("rx code 111 request wrong");
  a_tx_gate: assert property (p_tx_gate) else $error("tx request not gated");
  a_tx_route: assert property (p_tx_route) else $error("tx request not routed");
  a_rx_route: assert property (p_rx_route) else $error("rx request not routed");
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq high");
endmodule
bind sfwm_top sfwm_chk u_chk (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_shift_pop(tx_shift_pop), .tx_shift_valid(tx_shift_valid),
  .tx_fifo_empty(tx_fifo_empty), .rx_fifo_full(rx_fifo_full),
  .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .irq(irq));
`default_nettype wire

/* tb/sfwm_shift_model.sv */
// shift-logic stand-in: pops tx words and pushes numbered rx words on command
`timescale 1ns/1ns
`default_nettype none
module sfwm_shift_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // bench commands
  input  wire logic        pop_req,
  input  wire logic        push_req,
  // controller side
  output logic             tx_shift_pop,
  input  wire logic        tx_shift_valid,
  input  wire logic [15:0] tx_shift_word,
  output logic             rx_shift_push,
  output logic      [15:0] rx_shift_word,
  // last word taken from the tx fifo
  output logic      [15:0] got_word
);
  logic [15:0] seq_r;
  // one-cycle strobes; idle word bus toggles so a stale value never looks held
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_shift_pop  <= 1'b0;
      rx_shift_push <= 1'b0;
      rx_shift_word <= 16'h0000;
      seq_r         <= 16'h0000;
      got_word      <= 16'h0000;
    end else begin
      tx_shift_pop  <= pop_req;
      rx_shift_push <= push_req;
      rx_shift_word <= push_req ? seq_r + 16'h0001 : ~rx_shift_word;
      if (push_req) seq_r <= seq_r + 16'h0001;
      if (tx_shift_valid) got_word <= tx_shift_word;
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the fifo watermark controller
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic             core_clk = 1'b0;
  logic             reset = 1'b1;
  logic [7:0]       reg_addr = 8'h00;
  logic [15:0]      reg_wdata = 16'h0000;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic             pop_req = 1'b0;
  logic             push_req = 1'b0;
  logic [15:0]      rdv;
  wire logic [15:0] reg_rdata, tx_shift_word, rx_shift_word, got_word;
  wire logic        tx_shift_pop, tx_shift_valid, tx_fifo_empty, rx_shift_push;
  wire logic        rx_fifo_full, tx_dma_req, rx_dma_req, irq;
  int               errors = 0;
  int               n_compared = 0;
  int               cycles = 0;
  localparam logic [2:0] CODES [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam int         TXT [5] = '{16, 12, 8, 4, 1};
  localparam int         RXT [5] = '{1, 4, 8, 12, 16};
  // design and shift-side model
  sfwm_top dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_shift_pop(tx_shift_pop), .tx_shift_word(tx_shift_word),
    .tx_shift_valid(tx_shift_valid), .tx_fifo_empty(tx_fifo_empty),
    .rx_shift_push(rx_shift_push), .rx_shift_word(rx_shift_word),
    .rx_fifo_full(rx_fifo_full), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req),
    .irq(irq));
  sfwm_shift_model shifter (.core_clk(core_clk), .reset(reset), .pop_req(pop_req),
    .push_req(push_req), .tx_shift_pop(tx_shift_pop), .tx_shift_valid(tx_shift_valid),
    .tx_shift_word(tx_shift_word), .rx_shift_push(rx_shift_push),
    .rx_shift_word(rx_shift_word), .got_word(got_word));
  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  task automatic give_verdict();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // one pop and/or push by the shift side, settled afterwards
  task automatic shift(input logic p, input logic q);
    @(posedge core_clk);
    pop_req  <= p;
    push_req <= q;
    @(posedge core_clk);
    pop_req  <= 1'b0;
    push_req <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rd(sfwm_pkg::OFS_FIFO_CTRL, rdv);
    chk16(rdv, 16'h1000);
    wr(sfwm_pkg::OFS_FIFO_CTRL, 16'hffff);
    rd(sfwm_pkg::OFS_FIFO_CTRL, rdv);
    chk16(rdv, 16'hf0e0);
    wr(sfwm_pkg::OFS_REQ_EN, 16'hffff);
    rd(sfwm_pkg::OFS_REQ_EN, rdv);
    chk16(rdv, 16'h9900);
    // tx thresholds: fill past full, then drain through the shifter
    for (int c = 0; c < 5; c++) begin
      wr(sfwm_pkg::OFS_FIFO_CTRL, {CODES[c], 13'h0000});
      chk1(tx_dma_req, 1'b1);
      for (int n = 1; n <= 17; n++) begin
        wr(sfwm_pkg::OFS_TX_DATA, 16'(n));
        chk1(tx_dma_req, (16 - ((n > 16) ? 16 : n)) >= TXT[c]);
      end
      rd(sfwm_pkg::OFS_FIFO_CTRL, rdv);
      chk16(rdv, {CODES[c], 13'h0000});
      for (int i = 0; i < 16; i++) begin
        shift(1'b1, 1'b0);
        chk1(tx_dma_req, (i + 1) >= TXT[c]);
      end
      // the model takes the last word one edge after the shifter sees it
      @(posedge core_clk);
      #1;
      chk16(got_word, 16'h0010);
      chk1(tx_fifo_empty, 1'b1);
    end
    // rx thresholds: fill past full, then drain over the register port
    for (int c = 0; c < 5; c++) begin
      wr(sfwm_pkg::OFS_FIFO_CTRL, {8'h00, CODES[c], 5'h00});
      chk1(rx_dma_req, 1'b0);
      for (int n = 1; n <= 17; n++) begin
        shift(1'b0, 1'b1);
        chk1(rx_dma_req, ((n > 16) ? 16 : n) >= RXT[c]);
      end
      rd(sfwm_pkg::OFS_FIFO_CTRL, rdv);
      chk16(rdv, {8'h10, CODES[c], 5'h10});
      for (int i = 0; i < 16; i++) begin
        rd(sfwm_pkg::OFS_RX_DATA, rdv);
        chk16(rdv, 16'(17 * c + 1 + i));
        chk1(rx_dma_req, (15 - i) >= RXT[c]);
      end
    end
    // overflow events are sticky and cleared by reading
    rd(sfwm_pkg::OFS_IRQ_STAT, rdv);
    chk16(rdv, 16'h0014);
    rd(sfwm_pkg::OFS_IRQ_STAT, rdv);
    chk16(rdv, 16'h0000);
    // cpu routing of both requests
    wr(sfwm_pkg::OFS_FIFO_CTRL, 16'h0000);
    wr(sfwm_pkg::OFS_IRQ_MASK, 16'h0001);
    wr(sfwm_pkg::OFS_REQ_EN, 16'h1100);
    chk1(irq, 1'b1);
    chk1(tx_dma_req, 1'b0);
    wr(sfwm_pkg::OFS_IRQ_MASK, 16'h0000);
    chk1(irq, 1'b0);
    shift(1'b0, 1'b1);
    chk1(rx_dma_req, 1'b0);
    rd(sfwm_pkg::OFS_IRQ_STAT, rdv);
    chk16(rdv, 16'h0003);
    wr(sfwm_pkg::OFS_IRQ_MASK, 16'h0002);
    chk1(irq, 1'b1);
    // unmapped place reads zero and ignores writes
    rd(8'h20, rdv);
    chk16(rdv, 16'h0000);
    wr(8'h20, 16'hffff);
    rd(sfwm_pkg::OFS_FIFO_CTRL, rdv);
    chk16(rdv, 16'h1001);
    // underflow on both sides, then a status read drops the rx interrupt
    rd(sfwm_pkg::OFS_RX_DATA, rdv);
    chk16(rdv, 16'(17 * 5 + 1));
    rd(sfwm_pkg::OFS_RX_DATA, rdv);
    chk16(rdv, 16'h0000);
    shift(1'b1, 1'b0);
    chk1(tx_shift_valid, 1'b0);
    rd(sfwm_pkg::OFS_IRQ_STAT, rdv);
    chk16(rdv, 16'h002b);
    chk1(irq, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
